// File: fpc_protect_cmd.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpc_regs.svh"

// What this block does
// (R1) Config read: opcode in, 16 bits out.
// (R2) Config read repeats every 16 bits.
// (R3) Config program needs write enable latch.
// (R4) Config program needs exactly 16 data bits.
// (R5) Busy during program, then latch cleared.
// (R6) Lock read outputs 8 bits, repeating.
// (R7) Lock read answered only when idle.
// (R8) Lock clear zeroes lock bit, needs latch.
// (R9) Lock clear only after exactly 8 bits.
// (R10) Freeze sets lock bit 7, needs latch.
// (R11) Freeze only after exactly 8 bits.
// (R12) Password read: 64 bits, repeating.
// (R13) Password read ignored in password mode.
// (R14) Password program needs latch, no password mode.
// (R15) Password program needs exactly 64 bits.
// (R16) Unlock needs exactly 64 bits, busy meanwhile.
// (R17) Matching unlock sets lock bit, else ignored.
// (R18) Gang lock clears dynamic bits, needs latch.
// (R19) Gang lock only after exactly 8 bits.
// (R20) Gang lock busy for 70 microseconds.
// (R21) Host sets latch with write enable opcode.
// (R22) Quad mode moves four bits per clock.
// (R23) Latch-gated commands without latch change nothing.
// (R24) Status read works while busy.
module fpc_protect_cmd (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Serial link pins
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic [3:0]  io_i,
    output var  logic [3:0]  io_o,
    output var  logic [3:0]  io_oe_n_o,
    // Command mode
    input  wire logic        quad_mode_i,
    // Protection state
    output var  logic        busy_o,
    output var  logic        wel_o,
    output var  logic [15:0] protection_config_o,
    output var  logic [7:0]  protection_lock_o,
    output var  logic        dyb_gang_lock_o
);
    import fpc_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [63:0] swap_bytes(input logic [63:0] v);
        logic [63:0] r;
        for (int i = 0; i < 8; i++) begin
            r[8*i +: 8] = v[56-8*i +: 8];
        end
        return r;
    endfunction

    function automatic fpc_tx_s tx_source(input logic [7:0] op, input logic bsy, input logic we,
                                          input logic [15:0] c, input logic [7:0] l, input logic [63:0] p);
        fpc_tx_s s;
        s = '0;
        case (op)
            `FPC_OP_RD_STAT: begin
                s.ok = 1'b1; // R24
                s.len = `FPC_LEN_STAT;
                s.stream[56 + `FPC_STAT_BUSY] = bsy;
                s.stream[56 + `FPC_STAT_WEL] = we;
            end
            `FPC_OP_RD_CFG: begin
                s.ok = ~bsy;
                s.len = `FPC_LEN_CFG;
                s.stream = {c[7:0], c[15:8], 48'h0}; // R1
            end
            `FPC_OP_RD_LOCK: begin
                s.ok = ~bsy; // R7
                s.len = `FPC_LEN_LOCK;
                s.stream = {l, 56'h0}; // R6
            end
            `FPC_OP_RD_PWD: begin
                s.ok = ~bsy & c[`FPC_CFG_PWDMODE]; // R13
                s.len = `FPC_LEN_PWD;
                s.stream = swap_bytes(p); // R12
            end
            default: begin
                s.ok = 1'b0;
            end
        endcase
        return s;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    fpc_pins_s   pins_raw;
    fpc_pins_s   pins;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic [6:0]  step;
    logic [63:0] rx_shift;
    logic [6:0]  rx_inc;
    logic        opc_done;
    fpc_tx_s     rd_src;

    logic [6:0]  rx_cnt;
    logic [63:0] rx_data;
    logic [7:0]  opcode;
    logic        tx_active;
    logic [63:0] tx_stream;
    logic [6:0]  tx_cnt;
    logic [6:0]  tx_len;
    logic [3:0]  io_q;
    logic [3:0]  oe_n_q;
    logic [6:0]  next_rx_cnt;
    logic [63:0] next_rx_data;
    logic [7:0]  next_opcode;
    logic        next_tx_active;
    logic [63:0] next_tx_stream;
    logic [6:0]  next_tx_cnt;
    logic [6:0]  next_tx_len;
    logic [3:0]  next_io;
    logic [3:0]  next_oe_n;

    fpc_op_e     state;
    fpc_act_e    act;
    logic [10:0] timer;
    logic        write_enable_latch;
    logic [15:0] cfg;
    logic [7:0]  lock;
    logic [63:0] pwd;
    logic [63:0] op_data;
    logic        gang_q;
    logic [11:0] busy_len;
    fpc_op_e     next_state;
    fpc_act_e    next_act;
    logic [10:0] next_timer;
    logic        next_wel;
    logic [15:0] next_cfg;
    logic [7:0]  next_lock;
    logic [63:0] next_pwd;
    logic [63:0] next_op_data;
    logic        next_gang;
    logic [11:0] next_busy_len;

    logic        go;
    fpc_act_e    go_act;
    logic [10:0] go_time;
    logic [63:0] go_data;
    logic        busy;

    // ************************************************************
    // Link front end
    // ************************************************************
    assign pins_raw.cs_n = cs_n_i;
    assign pins_raw.sck  = sck_i;
    assign pins_raw.io   = io_i;

    fpc_pin_sync u_sync (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .pins_i     (pins_raw),
        .pins_o     (pins),
        .sck_rise_o (sck_rise),
        .sck_fall_o (sck_fall),
        .cs_rise_o  (cs_rise)
    );

    assign step     = quad_mode_i ? 7'h4 : 7'h1; // R22
    assign rx_shift = quad_mode_i ? {rx_data[59:0], pins.io} : {rx_data[62:0], pins.io[0]};
    assign rx_inc   = rx_cnt + step;
    assign opc_done = sck_rise && (rx_cnt < `FPC_OPC_BITS) && (rx_inc == `FPC_OPC_BITS);
    assign rd_src   = tx_source(opc_done ? rx_shift[7:0] : opcode, busy, write_enable_latch, cfg, lock, pwd);

    // Input is sampled on rising edges, output changes on falling edges.
    always_comb begin
        next_rx_cnt    = rx_cnt;
        next_rx_data   = rx_data;
        next_opcode    = opcode;
        next_tx_active = tx_active;
        next_tx_stream = tx_stream;
        next_tx_cnt    = tx_cnt;
        next_tx_len    = tx_len;
        next_io        = io_q;
        next_oe_n      = oe_n_q;
        if (pins.cs_n) begin
            next_rx_cnt    = 7'h0;
            next_tx_active = 1'b0;
            next_oe_n      = 4'hf;
        end else begin
            if (sck_rise) begin
                next_rx_data = rx_shift;
                if (rx_cnt < `FPC_RX_SAT) begin
                    next_rx_cnt = rx_inc;
                end
                if (opc_done) begin
                    next_opcode    = rx_shift[7:0]; // R1
                    next_tx_active = rd_src.ok;
                    next_tx_stream = rd_src.stream;
                    next_tx_len    = rd_src.len;
                    next_tx_cnt    = 7'h0;
                end
            end
            if (sck_fall && tx_active) begin
                next_io   = quad_mode_i ? tx_stream[63:60] : {2'h0, tx_stream[63], 1'b0}; // R22
                next_oe_n = quad_mode_i ? 4'h0 : 4'hd;
                if (7'(tx_cnt + step) == tx_len) begin
                    next_tx_stream = rd_src.stream; // R2
                    next_tx_cnt    = 7'h0;
                end else begin
                    next_tx_stream = quad_mode_i ? {tx_stream[59:0], 4'h0} : {tx_stream[62:0], 1'b0};
                    next_tx_cnt    = 7'(tx_cnt + step);
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_cnt    <= 7'h0;
            rx_data   <= 64'h0;
            opcode    <= 8'h0;
            tx_active <= 1'b0;
            tx_stream <= 64'h0;
            tx_cnt    <= 7'h0;
            tx_len    <= 7'h0;
            io_q      <= 4'h0;
            oe_n_q    <= 4'hf;
        end else begin
            rx_cnt    <= next_rx_cnt;
            rx_data   <= next_rx_data;
            opcode    <= next_opcode;
            tx_active <= next_tx_active;
            tx_stream <= next_tx_stream;
            tx_cnt    <= next_tx_cnt;
            tx_len    <= next_tx_len;
            io_q      <= next_io;
            oe_n_q    <= next_oe_n;
        end
    end

    // ************************************************************
    // Command decode at chip select release
    // ************************************************************
    // The opcode register may be stale on a short frame, so every check also needs an exact bit count.
    always_comb begin
        go      = 1'b0;
        go_act  = ACT_NONE;
        go_time = 11'(`FPC_PROG_CYC - 1);
        go_data = swap_bytes(rx_data);
        if (cs_rise && state == ST_IDLE) begin
            case (opcode)
                `FPC_OP_PG_CFG: begin
                    go      = write_enable_latch && rx_cnt == `FPC_CFG_END; // R3 R4 R23
                    go_act  = ACT_CFG;
                    go_data = {48'h0, rx_data[7:0], rx_data[15:8]};
                end
                `FPC_OP_CLR_LOCK: begin
                    go     = write_enable_latch && rx_cnt == `FPC_OPC_BITS; // R8 R9 R23
                    go_act = ACT_CLR;
                end
                `FPC_OP_FREEZE: begin
                    go     = write_enable_latch && rx_cnt == `FPC_OPC_BITS; // R10 R11 R23
                    go_act = ACT_FRZ;
                end
                `FPC_OP_PG_PWD: begin
                    go     = write_enable_latch && cfg[`FPC_CFG_PWDMODE] && rx_cnt == `FPC_PWD_END; // R14 R15 R23
                    go_act = ACT_PWD;
                end
                `FPC_OP_UNLOCK: begin
                    go     = rx_cnt == `FPC_PWD_END; // R16
                    go_act = ACT_UNLOCK;
                end
                `FPC_OP_GANG: begin
                    go      = write_enable_latch && rx_cnt == `FPC_OPC_BITS; // R18 R19 R23
                    go_act  = ACT_GANG;
                    go_time = 11'(`FPC_GANG_CYC - 1); // R20
                end
                default: begin
                    go = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Self-timed operations
    // ************************************************************
    // Config and password programming can only clear bits, as in the cell array, so a zero there never returns to one.
    always_comb begin
        next_state    = state;
        next_act      = act;
        next_timer    = timer;
        next_wel      = write_enable_latch;
        next_cfg      = cfg;
        next_lock     = lock;
        next_pwd      = pwd;
        next_op_data  = op_data;
        next_gang     = 1'b0;
        next_busy_len = busy ? 12'(busy_len + 12'h1) : 12'h0;
        case (state)
            ST_IDLE: begin
                if (go) begin
                    next_state   = ST_BUSY; // R5
                    next_act     = go_act;
                    next_timer   = go_time;
                    next_op_data = go_data;
                end else if (cs_rise && opcode == `FPC_OP_WRITE_ENABLE_CMD && rx_cnt == `FPC_OPC_BITS) begin
                    next_wel = 1'b1; // R21
                end
            end
            ST_BUSY: begin
                if (timer != 11'h0) begin
                    next_timer = timer - 11'h1;
                end else begin
                    next_state = ST_IDLE;
                    if (act != ACT_UNLOCK) begin
                        next_wel = 1'b0; // R5 R9 R11 R15
                    end
                    case (act)
                        ACT_CFG:    next_cfg = cfg & op_data[15:0];
                        ACT_CLR:    next_lock[`FPC_LOCK_BIT] = 1'b0; // R8
                        ACT_FRZ:    next_lock[`FPC_FREEZE_BIT] = 1'b1; // R10
                        ACT_PWD:    next_pwd = pwd & op_data;
                        ACT_UNLOCK: next_lock[`FPC_LOCK_BIT] = lock[`FPC_LOCK_BIT] | (op_data == pwd); // R17
                        ACT_GANG:   next_gang = 1'b1; // R18
                        default:    next_gang = 1'b0;
                    endcase
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state    <= ST_IDLE;
            act      <= ACT_NONE;
            timer    <= 11'h0;
            write_enable_latch      <= 1'b0;
            cfg      <= `FPC_CFG_RST;
            lock     <= `FPC_LOCK_RST;
            pwd      <= `FPC_PWD_RST;
            op_data  <= 64'h0;
            gang_q   <= 1'b0;
            busy_len <= 12'h0;
        end else begin
            state    <= next_state;
            act      <= next_act;
            timer    <= next_timer;
            write_enable_latch      <= next_wel;
            cfg      <= next_cfg;
            lock     <= next_lock;
            pwd      <= next_pwd;
            op_data  <= next_op_data;
            gang_q   <= next_gang;
            busy_len <= next_busy_len;
        end
    end

    assign busy                = state == ST_BUSY;
    assign busy_o              = busy;
    assign wel_o               = write_enable_latch;
    assign protection_config_o = cfg;
    assign protection_lock_o   = lock;
    assign dyb_gang_lock_o     = gang_q;
    assign io_o                = io_q;
    assign io_oe_n_o           = oe_n_q;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_start_busy;
        @(posedge clk_i) disable iff (!resetn_i) go |=> busy ##1 busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("Operation did not hold busy"); // R5

    property p_wel_clear;
        @(posedge clk_i) disable iff (!resetn_i) $fell(busy) && act != ACT_UNLOCK |-> !write_enable_latch;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("Latch not cleared at completion"); // R5

    property p_no_latch;
        @(posedge clk_i) disable iff (!resetn_i)
            cs_rise && !busy && !write_enable_latch && opcode != `FPC_OP_UNLOCK |=> !busy;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("Command ran without latch"); // R23

    property p_cfg_len;
        @(posedge clk_i) disable iff (!resetn_i)
            cs_rise && !busy && opcode == `FPC_OP_PG_CFG && rx_cnt != `FPC_CFG_END |=> !busy;
    endproperty
    a_cfg_len: assert property (p_cfg_len) else $error("Config program ran on bad length"); // R4

    property p_pwd_hidden;
        @(posedge clk_i) disable iff (!resetn_i)
            opc_done && rx_shift[7:0] == `FPC_OP_RD_PWD && !cfg[`FPC_CFG_PWDMODE] |=> !tx_active;
    endproperty
    a_pwd_hidden: assert property (p_pwd_hidden) else $error("Password read in password mode"); // R13

    property p_lock_busy;
        @(posedge clk_i) disable iff (!resetn_i)
            opc_done && rx_shift[7:0] == `FPC_OP_RD_LOCK |=> tx_active == !$past(busy);
    endproperty
    a_lock_busy: assert property (p_lock_busy) else $error("Lock read answer wrong for busy"); // R7

    property p_clear_lock;
        @(posedge clk_i) disable iff (!resetn_i) $fell(busy) && act == ACT_CLR |-> !lock[`FPC_LOCK_BIT];
    endproperty
    a_clear_lock: assert property (p_clear_lock) else $error("Lock bit not cleared"); // R8

    property p_freeze;
        @(posedge clk_i) disable iff (!resetn_i) $fell(busy) && act == ACT_FRZ |-> lock[`FPC_FREEZE_BIT];
    endproperty
    a_freeze: assert property (p_freeze) else $error("Freeze bit not set"); // R10

    property p_unlock;
        @(posedge clk_i) disable iff (!resetn_i)
            $fell(busy) && act == ACT_UNLOCK && op_data == pwd |-> lock[`FPC_LOCK_BIT];
    endproperty
    a_unlock: assert property (p_unlock) else $error("Matching unlock left lock bit clear"); // R17

    property p_gang_time;
        @(posedge clk_i) disable iff (!resetn_i)
            $fell(busy) && act == ACT_GANG |-> busy_len == 12'(`FPC_GANG_CYC) && dyb_gang_lock_o;
    endproperty
    a_gang_time: assert property (p_gang_time) else $error("Gang lock timing wrong"); // R20

    property p_drive_in_frame;
        @(posedge clk_i) disable iff (!resetn_i) io_oe_n_o != 4'hf |-> $past(pins.cs_n) == 1'b0;
    endproperty
    a_drive_in_frame: assert property (p_drive_in_frame) else $error("Pins driven outside a frame"); // R1

endmodule

`default_nettype wire

// File: fpc_regs.svh
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// ************************************************************
// Command opcodes
// ************************************************************
`define FPC_OP_WRITE_ENABLE_CMD      8'h06
`define FPC_OP_RD_STAT   8'h05
`define FPC_OP_RD_CFG    8'h2b
`define FPC_OP_PG_CFG    8'h2f
`define FPC_OP_RD_LOCK   8'ha7
`define FPC_OP_CLR_LOCK  8'ha6
`define FPC_OP_FREEZE    8'h91
`define FPC_OP_RD_PWD    8'he7
`define FPC_OP_PG_PWD    8'he8
`define FPC_OP_UNLOCK    8'he9
`define FPC_OP_GANG      8'h7e

// ************************************************************
// Frame lengths in bits
// ************************************************************
`define FPC_OPC_BITS     7'h08
`define FPC_CFG_END      7'h18
`define FPC_PWD_END      7'h48
`define FPC_RX_SAT       7'h7c
`define FPC_LEN_STAT     7'h08
`define FPC_LEN_CFG      7'h10
`define FPC_LEN_LOCK     7'h08
`define FPC_LEN_PWD      7'h40

// ************************************************************
// Field positions and reset values
// ************************************************************
`define FPC_CFG_PWDMODE  2
`define FPC_LOCK_BIT     0
`define FPC_FREEZE_BIT   7
`define FPC_STAT_BUSY    0
`define FPC_STAT_WEL     1
`define FPC_CFG_RST      16'hffff
`define FPC_LOCK_RST     8'h01
`define FPC_PWD_RST      64'hffff_ffff_ffff_ffff

// ************************************************************
// Timing
// ************************************************************
`define FPC_CLK_NS       40
`define FPC_GANG_US      70
`define FPC_PROG_US      10
`define FPC_GANG_CYC     ((`FPC_GANG_US * 1000) / `FPC_CLK_NS)
`define FPC_PROG_CYC     ((`FPC_PROG_US * 1000) / `FPC_CLK_NS)

`endif

// File: fpc_pkg.sv
`default_nettype none

package fpc_pkg;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } fpc_pins_s;

    typedef struct packed {
        logic        ok;
        logic [6:0]  len;
        logic [63:0] stream;
    } fpc_tx_s;

    typedef enum logic {ST_IDLE, ST_BUSY} fpc_op_e;

    typedef enum logic [2:0] {ACT_NONE, ACT_CFG, ACT_CLR, ACT_FRZ, ACT_PWD, ACT_UNLOCK, ACT_GANG} fpc_act_e;

endpackage

`default_nettype wire

// File: fpc_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module fpc_pin_sync (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // Raw pins
    input  wire fpc_pkg::fpc_pins_s pins_i,
    // Clean pins and edges
    output var  fpc_pkg::fpc_pins_s pins_o,
    output var  logic               sck_rise_o,
    output var  logic               sck_fall_o,
    output var  logic               cs_rise_o
);
    import fpc_pkg::*;

    localparam fpc_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};

    fpc_pins_s meta;
    fpc_pins_s sync;
    fpc_pins_s prev;
    fpc_pins_s next_meta;
    fpc_pins_s next_sync;
    fpc_pins_s next_prev;

    // Edges are taken between the second and third stage, so the first stage feeds only the second.
    always_comb begin
        next_meta = pins_i;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= PINS_IDLE;
            sync <= PINS_IDLE;
            prev <= PINS_IDLE;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    assign pins_o     = sync;
    assign sck_rise_o = sync.sck & ~prev.sck;
    assign sck_fall_o = ~sync.sck & prev.sck;
    assign cs_rise_o  = sync.cs_n & ~prev.cs_n;

endmodule

`default_nettype wire

// File: fpc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module fpc_host_model (
    // Clock
    input  wire logic       clk_i,
    // Mode and resolved wire levels
    input  wire logic       quad_i,
    input  wire logic [3:0] io_i,
    // Pins toward the device
    output var  logic       cs_n_o,
    output var  logic       sck_o,
    output var  logic [3:0] io_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        io_o = 4'h0;
    end

    // ************************************************************
    // Frame
    // ************************************************************
    // Data changes on the falling edge and is read at the next rise. A released line
    // toggles, so a stale bit never passes for data. The clock rests low between frames.
    task automatic xfer(input int nb, input logic [71:0] tx, input int nrd, output logic [63:0] rx);
        int w;
        w = quad_i ? 4 : 1;
        rx = 64'h0;
        cs_n_o <= 1'b0;
        io_o <= quad_i ? tx[71:68] : {3'h0, tx[71]};
        repeat (4) @(posedge clk_i);
        for (int k = 0; k < (nb + nrd) / w; k++) begin
            if (k >= nb / w) rx = quad_i ? {rx[59:0], io_i} : {rx[62:0], io_i[1]};
            sck_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            sck_o <= 1'b0;
            io_o <= (k + 1) * w < nb ? (quad_i ? tx[67 - 4 * k -: 4] : {3'h0, tx[70 - k]}) : ~io_o;
            repeat (5) @(posedge clk_i);
        end
        cs_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// File: fpc_protect_cmd_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_protect_cmd_tb;
    import fpc_pkg::*;

    logic              clk_i = 1'b0;
    logic              resetn_i = 1'b0;
    logic              quad = 1'b0;
    logic              cs_n, sck, gang, busy, write_enable_latch, drv;
    logic [3:0]        h_io, d_io, oe_n, io_w;
    logic [15:0]       cfg;
    logic [7:0]        lock;
    logic [63:0]       rx;
    int                fails = 0, cmp_count = 0, bl, gangs = 0;
    localparam logic [63:0] pw = 64'h0123456789abcdef;

    always #20 clk_i = ~clk_i;
    assign io_w = (oe_n & h_io) | (~oe_n & d_io);
    always @(posedge clk_i) begin
        gangs <= gangs + int'(gang);
        if (oe_n !== 4'hf) drv <= 1'b1;
    end

    fpc_protect_cmd fpc_protect_cmd_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sck_i(sck),
        .io_i(io_w), .io_o(d_io), .io_oe_n_o(oe_n), .quad_mode_i(quad), .busy_o(busy), .wel_o(write_enable_latch),
        .protection_config_o(cfg), .protection_lock_o(lock), .dyb_gang_lock_o(gang));
    fpc_host_model fpc_host_model_inst (.clk_i(clk_i), .quad_i(quad), .io_i(io_w), .cs_n_o(cs_n),
        .sck_o(sck), .io_o(h_io));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic xf(input int nb, input logic [71:0] tx, input int nrd = 0);
        drv <= 1'b0;
        fpc_host_model_inst.xfer(nb, tx, nrd, rx);
    endtask

    task automatic write_enable_cmd;
        xf(8, {`FPC_OP_WRITE_ENABLE_CMD, 64'h0});
    endtask

    // Sends a frame, then counts how many cycles busy stands.
    // Busy is already up when the frame returns, so that first cycle counts too.
    task automatic run(input int nb, input logic [71:0] tx);
        xf(nb, tx);
        bl = int'(busy === 1'b1);
        for (int n = 0; n < 3000 && (busy === 1'b1 || n < 8); n++) begin
            @(posedge clk_i);
            bl += int'(busy === 1'b1);
        end
    endtask

    function automatic logic [63:0] bsw(input logic [63:0] v);
        for (int i = 0; i < 8; i++) bsw[8 * i +: 8] = v[56 - 8 * i +: 8];
    endfunction

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk("reset", {busy, write_enable_latch, cfg, lock}, {2'b00, 16'hffff, 8'h01});
        run(24, {`FPC_OP_PG_CFG, 16'h3ca5, 48'h0});
        chk("cfg", {bl, cfg}, 48'hffff);
        write_enable_cmd;
        run(32, {`FPC_OP_PG_CFG, 16'h3ca5, 48'h0});
        chk("cfg", cfg, 16'hffff);
        run(24, {`FPC_OP_PG_CFG, 16'h3ca5, 48'h0});
        chk("busy time", bl, `FPC_PROG_CYC);
        chk("cfg", {write_enable_latch, cfg}, 17'h0a53c);
        xf(8, {`FPC_OP_RD_CFG, 64'h0}, 32);
        chk("cfg read", rx, 32'h3ca53ca5);
        xf(8, {`FPC_OP_RD_LOCK, 64'h0}, 16);
        chk("lock read", rx, 16'h0101);
        write_enable_cmd;
        run(16, {`FPC_OP_CLR_LOCK, 64'h0});
        chk("lock", lock, 8'h01);
        run(8, {`FPC_OP_CLR_LOCK, 64'h0});
        chk("lock", {write_enable_latch, lock}, 9'h000);
        write_enable_cmd;
        run(72, {`FPC_OP_PG_PWD, bsw(pw)});
        chk("pwd prog", bl, `FPC_PROG_CYC);
        xf(8, {`FPC_OP_RD_PWD, 64'h0}, 128);
        chk("pwd read", rx, bsw(pw));
        run(72, {`FPC_OP_UNLOCK, ~bsw(pw)});
        chk("lock", lock, 8'h00);
        run(72, {`FPC_OP_UNLOCK, bsw(pw)});
        chk("unlock time", bl, `FPC_PROG_CYC);
        chk("lock", lock, 8'h01);
        write_enable_cmd;
        run(8, {`FPC_OP_FREEZE, 64'h0});
        chk("lock", {write_enable_latch, lock}, 9'h081);
        quad <= 1'b1;
        @(posedge clk_i);
        write_enable_cmd;
        xf(8, {`FPC_OP_GANG, 64'h0});
        xf(8, {`FPC_OP_RD_STAT, 64'h0}, 8);
        chk("status", rx, 8'h03);
        xf(8, {`FPC_OP_RD_LOCK, 64'h0}, 8);
        chk("lock drive", drv, 1'b0);
        while (busy === 1'b1) @(posedge clk_i);
        @(posedge clk_i);
        chk("gang", {gangs, write_enable_latch}, 33'h2);
        quad <= 1'b0;
        @(posedge clk_i);
        run(8, {`FPC_OP_GANG, 64'h0});
        chk("gang", bl, 0);
        write_enable_cmd;
        run(8, {`FPC_OP_GANG, 64'h0});
        chk("gang time", bl, `FPC_GANG_CYC);
        @(posedge clk_i);
        chk("gangs", gangs, 2);
        write_enable_cmd;
        run(24, {`FPC_OP_PG_CFG, 16'hfbff, 48'h0});
        chk("cfg", cfg, 16'ha538);
        xf(8, {`FPC_OP_RD_PWD, 64'h0}, 64);
        chk("pwd hidden", drv, 1'b0);
        write_enable_cmd;
        run(72, {`FPC_OP_PG_PWD, 64'h0});
        chk("pwd prog", {bl, write_enable_latch}, 33'h1);
        report_and_stop;
    end

    // The tests need about 12000 cycles; eight times that means a hang.
    initial begin
        repeat (100000) @(posedge clk_i);
        fails++;
        report_and_stop;
    end
endmodule

`default_nettype wire
